/* serial_flash_pkg.sv */
// Purpose: Shared constants and types for the serial flash pin and
//          initialization sequencer.
// Assumes: System clock of 50 MHz.
// Notes:   Record header layout matches byte 0 of a command record.
package serial_flash_pkg;

  // Clock and serial clock timing.
  localparam int CLK_NS = 20;
  localparam int SCK_HALF_NS = 40;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] SCK_HALF_LAST = 3'(SCK_HALF_CYC - 1);

  // Pad turnaround: at least one and a half serial clock periods.
  localparam int TURN_TENTHS = 15;
  localparam int TURN_NS = (TURN_TENTHS * 2 * SCK_HALF_NS + 9) / 10;
  localparam int TURN_CYC = (TURN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] TURN_LAST = 3'(TURN_CYC - 1);

  // Microcode memory geometry.
  localparam int UC_WORDS = 16;
  localparam int UC_AW = 4;
  localparam int UC_DW = 32;
  localparam int PTR_W = 6;
  localparam logic [PTR_W-1:0] LAST_BYTE = 6'h3f;

  // Position of a byte inside a record.
  localparam logic [1:0] REL_HEAD = 2'h0;
  localparam logic [1:0] REL_WAIT_LO = 2'h1;
  localparam logic [1:0] REL_WAIT_HI = 2'h2;

  // Last beat index per byte for each bus width.
  localparam logic [2:0] LAST_BEAT_SINGLE = 3'h7;
  localparam logic [2:0] LAST_BEAT_DUAL = 3'h3;
  localparam logic [2:0] LAST_BEAT_QUAD = 3'h1;

  localparam logic [3:0] LINES_IDLE = 4'hf;
  localparam logic [3:0] OE_ALL = 4'hf;

  typedef enum logic [1:0] {
    WIDTH_SINGLE = 2'h0,
    WIDTH_DUAL = 2'h1,
    WIDTH_QUAD = 2'h2,
    WIDTH_RSVD = 2'h3
  } bus_width_t;

  typedef struct packed {
    logic [4:0] payloadByteCount;
    bus_width_t transmitBusWidth;
    logic valid;
  } record_head_t;

  localparam record_head_t HEAD_RESET = '{5'h00, WIDTH_SINGLE, 1'b0};

  typedef struct packed {
    logic sck;
    logic csN;
    logic [3:0] dataOut;
    logic [3:0] dataOe;
  } flash_pins_t;

  localparam flash_pins_t PINS_IDLE = '{1'b0, 1'b1, LINES_IDLE, OE_ALL};

  typedef struct packed {
    logic en;
    logic [UC_AW-1:0] addr;
    logic [UC_DW-1:0] data;
  } ucode_write_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_HDR = 3'h1,
    S_PAY = 3'h3,
    S_DRAIN = 3'h2,
    S_WAIT = 3'h6,
    S_DONE = 3'h7
  } seq_state_t;

endpackage

/* ucode_mem.sv */
// Purpose: Sixteen-word microcode store for the initialization records.
// Assumes: Contents sit in a retained supply domain, so no reset.
// Notes:   Read data come out of a register one cycle after the address.
`timescale 1ns/1ps
module ucode_mem (
  input wire logic clk,
  input serial_flash_pkg::ucode_write_t wr,
  input wire logic [serial_flash_pkg::UC_AW-1:0] rdAddr,
  output logic [serial_flash_pkg::UC_DW-1:0] rdData
);

  logic [serial_flash_pkg::UC_DW-1:0] words [serial_flash_pkg::UC_WORDS];

  always_ff @(posedge clk) begin
    if (wr.en) begin
      words[wr.addr] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    rdData <= words[rdAddr];
  end

endmodule

/* serial_flash_init_seq.sv */
// Purpose: Serial flash pin interface and hardware initialization sequencer.
// Assumes: 50 MHz clk; rcOscSixteenMeg and flashDataIn are asynchronous.
// Notes:   Serial clock is clk divided down, mode 0 (idles low).
//
// How it works
// - Block drives serial clock and active-low select; master only.
// - Single: line0 out, line1 in; dual lines 0-1 two-way; quad all four; the sequencer drives all four lines in every width.
// - Lines 2 and 3 are general outputs unless quad mode.
// - Pins always driven except reading; direction changes spaced 1.5 clocks.
// - Every data line idles at one from clock enable onward.
// - Software line values and enables apply only while select is low.
// - Serial clock is clk divided by four (12.5 MHz at 50 MHz clk), mode 0 only.
// - Two slave ports: control registers and microcode memory.
// - Signals crossing clock domains are resynchronised to be seen correctly.
// - Microcode memory holds sixteen 32-bit words retained through sleep.
// - After wake-up records are decoded and sent before the processor runs.
// - Replay is coordinated with power management by request and acknowledge.
// - Byte 0 holds payload count, bus width and valid flag.
// - Width field: 0 single, 1 dual, 2 quad, 3 reserved.
// - Valid flag one means record valid, zero means not valid.
// - Bytes 1 and 2 give a wait count, low byte first.
// - The wait counts cycles of the 16 MHz RC clock.
// - Payload bytes 3 onward go out under one select assertion.
`timescale 1ns/1ps
module serial_flash_init_seq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rcOscSixteenMeg,
  input wire logic initReq,
  output logic initAck,
  output logic seqBusy,
  input serial_flash_pkg::ucode_write_t ucWrite,
  input wire logic manualCs,
  input wire logic [3:0] lineOutValue,
  input wire logic [3:0] lineOutEnable,
  input wire logic [3:0] flashDataIn,
  output serial_flash_pkg::flash_pins_t flashPins,
  output logic [3:0] lineSample
);

  serial_flash_pkg::seq_state_t state;
  serial_flash_pkg::record_head_t head;
  serial_flash_pkg::record_head_t curHead;
  serial_flash_pkg::flash_pins_t next_pins;
  logic [serial_flash_pkg::PTR_W-1:0] bytePtr;
  logic [serial_flash_pkg::UC_DW-1:0] rdData;
  logic [7:0] curByte;
  logic phase;
  logic [1:0] relIdx;
  logic [15:0] waitCnt;
  logic [4:0] remain;
  logic endHit;
  logic csActive;
  logic [3:0] dinMeta;
  logic [3:0] dinSync;
  logic rcMeta;
  logic rcSync;
  logic rcPrev;
  logic rcEdge;
  logic [2:0] divCnt;
  logic halfTick;
  logic [7:0] fifoMem [2];
  logic wrSel;
  logic rdSel;
  logic [1:0] fifoCount;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoPush;
  logic fifoPop;
  logic sck;
  logic shActive;
  logic [7:0] shReg;
  logic [2:0] beatCnt;
  logic manualMode;
  logic [3:0] wantOe;
  logic [3:0] oeApplied;
  logic [2:0] turnCnt;
  logic [4:0] sentCount;

  function automatic logic [2:0] lastBeat(
    input serial_flash_pkg::bus_width_t w
  );
    unique case (w)
      serial_flash_pkg::WIDTH_DUAL: lastBeat = serial_flash_pkg::LAST_BEAT_DUAL;
      serial_flash_pkg::WIDTH_QUAD: lastBeat = serial_flash_pkg::LAST_BEAT_QUAD;
      serial_flash_pkg::WIDTH_SINGLE,
      serial_flash_pkg::WIDTH_RSVD: lastBeat = serial_flash_pkg::LAST_BEAT_SINGLE;
    endcase
  endfunction

  function automatic logic [7:0] shiftBeat(
    input logic [7:0] v,
    input serial_flash_pkg::bus_width_t w
  );
    unique case (w)
      serial_flash_pkg::WIDTH_DUAL: shiftBeat = {v[5:0], 2'h0};
      serial_flash_pkg::WIDTH_QUAD: shiftBeat = {v[3:0], 4'h0};
      serial_flash_pkg::WIDTH_SINGLE,
      serial_flash_pkg::WIDTH_RSVD: shiftBeat = {v[6:0], 1'h0};
    endcase
  endfunction

  // Unused lines stay at one; dual and quad put the high bit on the top line.
  function automatic logic [3:0] lineWord(
    input logic [7:0] v,
    input serial_flash_pkg::bus_width_t w
  );
    lineWord = serial_flash_pkg::LINES_IDLE;
    unique case (w)
      serial_flash_pkg::WIDTH_DUAL: lineWord[1:0] = v[7:6];
      serial_flash_pkg::WIDTH_QUAD: lineWord = v[7:4];
      serial_flash_pkg::WIDTH_SINGLE,
      serial_flash_pkg::WIDTH_RSVD: lineWord[0] = v[7];
    endcase
  endfunction

  ucode_mem uMem (
    .clk(clk),
    .wr(ucWrite),
    .rdAddr(bytePtr[serial_flash_pkg::PTR_W-1:2]),
    .rdData(rdData)
  );

  // Records are packed byte by byte, least significant byte first.
  assign curByte = 8'(rdData >> {bytePtr[1:0], 3'h0});
  assign curHead = serial_flash_pkg::record_head_t'(curByte);

  // Pin inputs pass two flip-flops before any logic reads them.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dinMeta <= serial_flash_pkg::LINES_IDLE;
      dinSync <= serial_flash_pkg::LINES_IDLE;
      lineSample <= serial_flash_pkg::LINES_IDLE;
      rcMeta <= 1'b0;
      rcSync <= 1'b0;
      rcPrev <= 1'b0;
    end else begin
      dinMeta <= flashDataIn;
      dinSync <= dinMeta;
      lineSample <= dinSync;
      rcMeta <= rcOscSixteenMeg;
      rcSync <= rcMeta;
      rcPrev <= rcSync;
    end
  end

  assign rcEdge = rcSync & ~rcPrev;

  // Serial clock divider: one half period per halfTick.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCnt <= 3'h0;
    end else if (halfTick) begin
      divCnt <= 3'h0;
    end else begin
      divCnt <= divCnt + 3'h1;
    end
  end

  assign halfTick = divCnt == serial_flash_pkg::SCK_HALF_LAST;

  assign fifoInReady = fifoCount != 2'h2;
  assign fifoOutValid = fifoCount != 2'h0;
  assign fifoPush = state == serial_flash_pkg::S_PAY && phase && !endHit &&
    fifoInReady;

  // Record sequencer.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= serial_flash_pkg::S_IDLE;
      bytePtr <= '0;
      phase <= 1'b0;
      relIdx <= serial_flash_pkg::REL_HEAD;
      head <= serial_flash_pkg::HEAD_RESET;
      waitCnt <= 16'h0000;
      remain <= 5'h00;
      endHit <= 1'b0;
      csActive <= 1'b0;
    end else begin
      unique case (state)
        serial_flash_pkg::S_IDLE: begin
          if (initReq) begin
            state <= serial_flash_pkg::S_HDR;
            bytePtr <= '0;
            phase <= 1'b0;
            relIdx <= serial_flash_pkg::REL_HEAD;
            endHit <= 1'b0;
          end
        end
        serial_flash_pkg::S_HDR: begin
          if (endHit) begin
            state <= serial_flash_pkg::S_DONE;
          end else if (!phase) begin
            phase <= 1'b1;
          end else begin
            phase <= 1'b0;
            bytePtr <= bytePtr + 6'h01;
            endHit <= bytePtr == serial_flash_pkg::LAST_BYTE;
            if (relIdx == serial_flash_pkg::REL_HEAD) begin
              head <= curHead;
              relIdx <= serial_flash_pkg::REL_WAIT_LO;
              if (!curHead.valid) begin
                state <= serial_flash_pkg::S_DONE;
              end
            end else if (relIdx == serial_flash_pkg::REL_WAIT_LO) begin
              waitCnt[7:0] <= curByte;
              relIdx <= serial_flash_pkg::REL_WAIT_HI;
            end else begin
              waitCnt[15:8] <= curByte;
              relIdx <= serial_flash_pkg::REL_HEAD;
              remain <= head.payloadByteCount;
              if (head.payloadByteCount == 5'h00) begin
                state <= serial_flash_pkg::S_WAIT;
              end else begin
                state <= serial_flash_pkg::S_PAY;
                csActive <= 1'b1;
              end
            end
          end
        end
        serial_flash_pkg::S_PAY: begin
          if (endHit) begin
            state <= serial_flash_pkg::S_DRAIN;
          end else if (!phase) begin
            phase <= 1'b1;
          end else if (fifoInReady) begin
            phase <= 1'b0;
            bytePtr <= bytePtr + 6'h01;
            endHit <= bytePtr == serial_flash_pkg::LAST_BYTE;
            remain <= remain - 5'h01;
            if (remain == 5'h01) begin
              state <= serial_flash_pkg::S_DRAIN;
            end
          end
        end
        serial_flash_pkg::S_DRAIN: begin
          if (!fifoOutValid && !shActive) begin
            csActive <= 1'b0;
            state <= serial_flash_pkg::S_WAIT;
          end
        end
        serial_flash_pkg::S_WAIT: begin
          if (waitCnt == 16'h0000) begin
            state <= endHit ? serial_flash_pkg::S_DONE :
              serial_flash_pkg::S_HDR;
          end else if (rcEdge) begin
            waitCnt <= waitCnt - 16'h0001;
          end
        end
        serial_flash_pkg::S_DONE: begin
          if (!initReq) begin
            state <= serial_flash_pkg::S_IDLE;
          end
        end
        default: begin
          state <= serial_flash_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Two-entry byte buffer between the memory reader and the shifter.
  always_ff @(posedge clk) begin
    if (fifoPush) begin
      fifoMem[wrSel] <= curByte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrSel <= 1'b0;
      rdSel <= 1'b0;
      fifoCount <= 2'h0;
    end else begin
      if (fifoPush) begin
        wrSel <= ~wrSel;
      end
      if (fifoPop) begin
        rdSel <= ~rdSel;
      end
      fifoCount <= fifoCount + 2'(fifoPush) - 2'(fifoPop);
    end
  end

  assign fifoPop = halfTick && csActive && fifoOutValid &&
    (!shActive || (sck && beatCnt == 3'h0));

  // Mode 0 shifter: data change on the falling edge, flash samples on rise.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck <= 1'b0;
      shActive <= 1'b0;
      shReg <= 8'hff;
      beatCnt <= 3'h0;
    end else if (halfTick) begin
      if (!shActive) begin
        if (fifoPop) begin
          shReg <= fifoMem[rdSel];
          beatCnt <= lastBeat(head.transmitBusWidth);
          shActive <= 1'b1;
        end
      end else if (!sck) begin
        sck <= 1'b1;
      end else begin
        sck <= 1'b0;
        if (beatCnt != 3'h0) begin
          shReg <= shiftBeat(shReg, head.transmitBusWidth);
          beatCnt <= beatCnt - 3'h1;
        end else if (fifoPop) begin
          shReg <= fifoMem[rdSel];
          beatCnt <= lastBeat(head.transmitBusWidth);
        end else begin
          shActive <= 1'b0;
        end
      end
    end
  end

  assign manualMode = manualCs && state == serial_flash_pkg::S_IDLE;
  assign wantOe = manualMode ? lineOutEnable : serial_flash_pkg::OE_ALL;

  // Pad direction changes are held apart by the turnaround time.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oeApplied <= serial_flash_pkg::OE_ALL;
      turnCnt <= 3'h0;
    end else if (turnCnt != 3'h0) begin
      turnCnt <= turnCnt - 3'h1;
    end else if (wantOe != oeApplied) begin
      oeApplied <= wantOe;
      turnCnt <= serial_flash_pkg::TURN_LAST;
    end
  end

  always_comb begin
    next_pins = serial_flash_pkg::PINS_IDLE;
    next_pins.dataOe = oeApplied;
    if (csActive) begin
      next_pins.csN = 1'b0;
      next_pins.sck = sck;
      next_pins.dataOut = lineWord(shReg, head.transmitBusWidth);
    end else if (manualMode) begin
      next_pins.csN = 1'b0;
      next_pins.dataOut = lineOutValue;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flashPins <= serial_flash_pkg::PINS_IDLE;
      initAck <= 1'b0;
      seqBusy <= 1'b0;
    end else begin
      flashPins <= next_pins;
      initAck <= state == serial_flash_pkg::S_DONE && initReq;
      seqBusy <= state != serial_flash_pkg::S_IDLE &&
        state != serial_flash_pkg::S_DONE;
    end
  end

  // Bytes handed to the shifter in the current envelope, for checking.
  always_ff @(posedge clk) begin
    if (!rst_n || state == serial_flash_pkg::S_HDR) begin
      sentCount <= 5'h00;
    end else if (fifoPop) begin
      sentCount <= sentCount + 5'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_idle_cs_high: assert property (
    state == serial_flash_pkg::S_IDLE && !manualCs && !csActive |=>
      flashPins.csN && !flashPins.sck)
    else $error("select or clock active while idle");

  chk_idle_lines_one: assert property (
    flashPins.csN |-> flashPins.dataOut == serial_flash_pkg::LINES_IDLE)
    else $error("data lines not at one with select high");

  chk_manual_apply: assert property (
    manualMode && !csActive |=> !flashPins.csN &&
      flashPins.dataOut == $past(lineOutValue))
    else $error("manual line value not applied under select");

  chk_turn_spacing: assert property (
    oeApplied != $past(oeApplied) |=> $stable(oeApplied)[*5])
    else $error("pad direction changed too soon");

  chk_invalid_stop: assert property (
    state == serial_flash_pkg::S_HDR && phase && !endHit &&
      relIdx == serial_flash_pkg::REL_HEAD && !curHead.valid |=>
      state == serial_flash_pkg::S_DONE)
    else $error("invalid record did not stop the sequencer");

  chk_wait_hold: assert property (
    state == serial_flash_pkg::S_WAIT && !rcEdge && waitCnt != 16'h0000 |=>
      waitCnt == $past(waitCnt))
    else $error("wait counter moved without an RC edge");

  chk_wait_step: assert property (
    state == serial_flash_pkg::S_WAIT && rcEdge && waitCnt != 16'h0000 |=>
      waitCnt == $past(waitCnt) - 16'h0001)
    else $error("wait counter did not step on an RC edge");

  chk_quad_beats: assert property (
    fifoPop && head.transmitBusWidth == serial_flash_pkg::WIDTH_QUAD |=>
      beatCnt == serial_flash_pkg::LAST_BEAT_QUAD)
    else $error("quad byte not split into two beats");

  chk_payload_count: assert property (
    state == serial_flash_pkg::S_DRAIN && !fifoOutValid && !shActive |->
      sentCount == head.payloadByteCount || endHit)
    else $error("payload byte count mismatch in envelope");

  chk_ack_done: assert property (
    state == serial_flash_pkg::S_DONE && initReq && !initAck |=>
      initAck ##1 initAck)
    else $error("acknowledge missing after replay");

  cov_replay_done: cover property (
    state == serial_flash_pkg::S_WAIT ##1 state == serial_flash_pkg::S_DONE);
  cov_quad_cmd: cover property (
    fifoPop && head.transmitBusWidth == serial_flash_pkg::WIDTH_QUAD);
  cov_fifo_full: cover property (fifoCount == 2'h2);
  cov_wait_edge: cover property (
    state == serial_flash_pkg::S_WAIT && rcEdge && waitCnt != 16'h0000);

endmodule

/* flash_model.sv */
// Purpose: Behavioural serial flash seen from its pins.
// Assumes: Mode 0 clocking; width per select envelope comes from the bench.
// Notes:   Released lines show resp under select and the inverse of their last level when deselected.
`timescale 1ns/1ps
module flash_model (
  input serial_flash_pkg::flash_pins_t pins,
  input serial_flash_pkg::bus_width_t firstWidth,
  input serial_flash_pkg::bus_width_t laterWidth,
  input wire logic [3:0] resp,
  input wire logic clear,
  output logic [3:0] drive,
  output logic [7:0] gotCount,
  output logic [7:0] envCount,
  output logic [7:0] protoErr
);
  logic [7:0] got [0:63];
  logic [7:0] sh;
  int nbits;
  serial_flash_pkg::bus_width_t w;
  initial begin
    gotCount = 8'h00;
    envCount = 8'h00;
    protoErr = 8'h00;
    nbits = 0;
    drive = 4'h0;
    sh = 8'h00;
    w = serial_flash_pkg::WIDTH_SINGLE;
  end
  always @(posedge clear) begin
    gotCount = 8'h00;
    envCount = 8'h00;
    protoErr = 8'h00;
  end
  always @(negedge pins.csN) begin
    if (pins.sck !== 1'b0) protoErr++;
    w = (envCount == 8'h00) ? firstWidth : laterWidth;
    envCount++;
    nbits = 0;
  end
  always @(posedge pins.csN) begin
    if (nbits != 0) protoErr++;
  end
  always @(posedge pins.sck) begin
    if (pins.csN !== 1'b0) protoErr++;
    if (pins.dataOe !== 4'hf) protoErr++;
    if (w != serial_flash_pkg::WIDTH_QUAD && pins.dataOut[3:2] !== 2'b11)
      protoErr++;
    case (w)
      serial_flash_pkg::WIDTH_DUAL: begin
        sh = {sh[5:0], pins.dataOut[1], pins.dataOut[0]};
        nbits += 2;
      end
      serial_flash_pkg::WIDTH_QUAD: begin
        sh = {sh[3:0], pins.dataOut};
        nbits += 4;
      end
      default: begin
        sh = {sh[6:0], pins.dataOut[0]};
        nbits += 1;
      end
    endcase
    if (nbits == 8) begin
      got[gotCount[5:0]] = sh;
      gotCount++;
      nbits = 0;
    end
  end
  // A deselected flash does not hold its last level, so the lines move.
  always @(pins.csN or resp) begin
    if (!pins.csN) drive = resp;
    else drive = ~drive;
  end
endmodule

/* tb_top.sv */
// Purpose: Self-checking bench for the flash pins and init sequencer.
// Assumes: Memory loaded through the write port before each replay.
// Notes:   Pin levels are resolved here from the block's enables and the flash drive.
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_n, rcOsc, initReq, manualCs, initAck, seqBusy, clear;
  logic prevCs;
  logic [3:0] lineOutValue, lineOutEnable, resp, pinLevel, lineSample;
  logic [3:0] drive, prevOe;
  logic [7:0] gotCount, envCount, protoErr;
  logic [7:0] mem [0:63];
  serial_flash_pkg::ucode_write_t ucWrite;
  serial_flash_pkg::flash_pins_t flashPins;
  serial_flash_pkg::bus_width_t w0, w1;
  int bad_count, cmp_count, cyc, lastOe, csRise, gap;
  assign pinLevel = (flashPins.dataOe & flashPins.dataOut) |
                    (~flashPins.dataOe & drive);
  serial_flash_init_seq dut_u (.clk(clk), .rst_n(rst_n),
    .rcOscSixteenMeg(rcOsc), .initReq(initReq), .initAck(initAck),
    .seqBusy(seqBusy), .ucWrite(ucWrite), .manualCs(manualCs),
    .lineOutValue(lineOutValue), .lineOutEnable(lineOutEnable),
    .flashDataIn(pinLevel), .flashPins(flashPins), .lineSample(lineSample));
  flash_model flash_u (.pins(flashPins), .firstWidth(w0), .laterWidth(w1),
    .resp(resp), .clear(clear), .drive(drive), .gotCount(gotCount),
    .envCount(envCount), .protoErr(protoErr));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    rcOsc = 1'b0;
    #7;
    forever #80 rcOsc = ~rcOsc;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen,
               exp);
    end
  endtask
  task automatic wrap_up;
    check(protoErr, 0, "flash side protocol");
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (flashPins.dataOe !== prevOe) begin
      if (rst_n) check(cyc - lastOe >= serial_flash_pkg::TURN_CYC, 1,
                       "turnaround");
      lastOe = cyc;
      prevOe = flashPins.dataOe;
    end
    if (flashPins.csN && !prevCs) csRise = cyc;
    if (!flashPins.csN && prevCs) gap = cyc - csRise;
    prevCs = flashPins.csN;
    if (cyc == 40000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic rec(input int at, input logic [4:0] cnt,
                     input logic [1:0] w, input logic [15:0] wt);
    mem[at] = {cnt, w, 1'b1};
    mem[at + 1] = wt[7:0];
    mem[at + 2] = wt[15:8];
  endtask
  task automatic loadMem;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      ucWrite = '{1'b1, 4'(i),
                  {mem[4*i+3], mem[4*i+2], mem[4*i+1], mem[4*i]}};
    end
    @(negedge clk);
    ucWrite.en = 1'b0;
  endtask
  task automatic replay;
    int n;
    logic sawBusy;
    sawBusy = 1'b0;
    loadMem();
    @(negedge clk);
    clear = 1'b1;
    initReq = 1'b1;
    @(negedge clk);
    clear = 1'b0;
    n = 0;
    while (initAck !== 1'b1 && n < 8000) begin
      @(negedge clk);
      sawBusy |= (seqBusy === 1'b1);
      n++;
    end
    check(sawBusy, 1, "busy during replay");
    check(initAck, 1, "ack raised");
    check(seqBusy, 0, "busy at ack");
    @(negedge clk);
    check(initAck, 1, "ack holds");
    initReq = 1'b0;
    n = 0;
    while (initAck !== 1'b0 && n < 10) begin
      @(negedge clk);
      n++;
    end
    check(initAck, 0, "ack dropped");
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  initial begin
    {rst_n, initReq, manualCs, clear} = 4'h0;
    lineOutValue = 4'hf;
    lineOutEnable = 4'hf;
    resp = 4'h0;
    ucWrite = '0;
    w0 = serial_flash_pkg::WIDTH_SINGLE;
    w1 = serial_flash_pkg::WIDTH_SINGLE;
    {bad_count, cmp_count, cyc, csRise, gap} = '0;
    lastOe = -100;
    prevOe = 4'hf;
    prevCs = 1'b1;
    idle(4);
    rst_n = 1'b1;
    check(flashPins, serial_flash_pkg::PINS_IDLE, "idle pins");
    check(lineSample, 4'hf, "idle sample");
    lineOutValue = 4'h0;
    lineOutEnable = 4'h0;
    idle(4);
    check(flashPins, serial_flash_pkg::PINS_IDLE, "no select");
    $display("test reset done");
    manualCs = 1'b1;
    lineOutValue = 4'h5;
    lineOutEnable = 4'hd;
    resp = 4'h2;
    idle(2);
    check({flashPins.csN, flashPins.dataOut}, 5'h05, "select");
    idle(8);
    check(flashPins.dataOe, 4'hd, "enables");
    idle(5);
    check(lineSample, 4'h7, "read line1 high");
    resp = 4'h0;
    idle(5);
    check(lineSample, 4'h5, "read line1 low");
    lineOutEnable = 4'h0;
    idle(8);
    check(flashPins.dataOe, 4'h0, "all released");
    check(lineSample, 4'h0, "released read");
    manualCs = 1'b0;
    idle(16);
    check(flashPins, serial_flash_pkg::PINS_IDLE, "back idle");
    $display("test manual done");
    for (int w = 0; w < 4; w++) begin
      for (int i = 0; i < 64; i++) mem[i] = 8'h00;
      rec(0, 5'd2, 2'(w), 16'h0000);
      mem[3] = 8'ha5;
      mem[4] = 8'h3c;
      w0 = (w == 3) ? serial_flash_pkg::WIDTH_SINGLE :
                      serial_flash_pkg::bus_width_t'(w);
      replay();
      check(envCount, 1, "one envelope");
      check(gotCount, 2, "byte count");
      check({flash_u.got[0], flash_u.got[1]}, 16'ha53c, "width");
      $display("test width %0d done", w);
    end
    for (int i = 0; i < 64; i++) mem[i] = 8'(i * 17 + 3);
    rec(0, 5'd6, 2'h0, 16'h0005);
    rec(9, 5'd1, 2'h2, 16'h0000);
    mem[13] = 8'h00;
    rec(14, 5'd1, 2'h0, 16'h0000);
    w1 = serial_flash_pkg::WIDTH_QUAD;
    replay();
    check(envCount, 2, "stop at invalid");
    check(gotCount, 7, "chain bytes");
    for (int k = 0; k < 6; k++) check(flash_u.got[k], mem[3 + k], "pay");
    check(flash_u.got[6], mem[12], "packed record");
    check(gap >= 32 && gap <= 80, 1, "rc wait");
    $display("test chain done");
    for (int i = 0; i < 64; i++) mem[i] = 8'(i * 7 + 1);
    rec(0, 5'd31, 2'h0, 16'h0000);
    rec(34, 5'd29, 2'h0, 16'h0000);
    w1 = serial_flash_pkg::WIDTH_SINGLE;
    replay();
    check(envCount, 2, "end envelopes");
    check(gotCount, 58, "end bytes");
    check(flash_u.got[57], mem[63], "last word");
    $display("test memory end done");
    for (int i = 0; i < 64; i++) mem[i] = 8'h00;
    rec(0, 5'd1, 2'h0, 16'h0004);
    mem[3] = 8'h06;
    rec(4, 5'd1, 2'h0, 16'h0004);
    mem[7] = 8'h06;
    replay();
    check(envCount, 2, "repeat envelopes");
    check(gotCount, 2, "repeat count");
    check({flash_u.got[0], flash_u.got[1]}, 16'h0606, "repeat");
    check(gap >= 24 && gap <= 80, 1, "repeat wait");
    $display("test repeat done");
    wrap_up();
  end
endmodule
